// >>> hdl/adcd_top.sv
// Purpose: Control/status register and data paths of a two-converter memory transfer engine
// Assumes: Converters and memory arbiter run on CLK_SYS; APB slave for software
// Notes: Each converter path holds one buffer word plus one held word behind it
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Enable bit reads one while engine busy
// - Complete flag set when work done, idle
// - Mode bit selects execution scheme zero/one
// - Second converter keeps its own error flag
// - First converter error on lost result
// - Warning enable gates only warning interrupts
// - Warning when result meets full buffer
//
// The APB interface to the registers and the register addresses are this design's own decisions.
module adcd_top (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Converter results
    input wire adcd_pkg::adcd_conv_type CONV0,
    input wire adcd_pkg::adcd_conv_type CONV1,
    // Memory write port
    output adcd_pkg::adcd_mem_type MEM_WR,
    input wire logic MEM_GNT,
    // Mode and interrupt
    output logic EXEC_MODE,
    output logic IRQ
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    adcd_pkg::adcd_state_type state; // Engine state
    logic [7:0] flags; // Sticky flags, control-register layout
    logic mode; // Execution mode select
    logic warn_en; // Warning interrupt enable
    logic [7:0] irq_en; // Interrupt enable, same layout
    logic [15:0] count; // Words to move per operation
    logic [15:0] done_cnt; // Words moved so far
    logic [1:0] buf_full; // Buffer word waiting for memory
    logic [1:0] hold_full; // Converter register word waiting for buffer
    logic [15:0] buf_data [0:1]; // Buffer words
    logic [15:0] hold_data [0:1]; // Held words
    logic access; // APB access phase
    logic wr_now; // Write takes effect this edge
    logic ctrl_wr; // Control register written
    logic start; // Software start request
    logic stop; // Software stop request
    logic mem_done; // Memory accepted a word
    logic last_word; // Accepted word completes operation
    logic [7:0] set_flags; // Hardware flag events
    logic [7:0] clr_flags; // Software flag clears
    logic [7:0] ctrl_read; // Control register read view
    logic [31:0] next_prdata; // Read mux
    logic next_slverr; // Unmapped address answer
    logic [1:0] conv_valid; // Valid of both converters
    logic [15:0] conv_data [0:1]; // Data of both converters

    // Address decode used by read and write paths
    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == adcd_pkg::OFS_CTRL) || (addr == adcd_pkg::OFS_IRQ_STAT) ||
                 (addr == adcd_pkg::OFS_IRQ_CLR) || (addr == adcd_pkg::OFS_IRQ_EN) ||
                 (addr == adcd_pkg::OFS_COUNT);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus strobes
    assign access = PSEL && PENABLE;
    assign wr_now = access && PREADY && PWRITE;
    assign ctrl_wr = wr_now && (PADDR == adcd_pkg::OFS_CTRL);
    assign start = ctrl_wr && PWDATA[adcd_pkg::BIT_ENABLE];
    assign stop = ctrl_wr && !PWDATA[adcd_pkg::BIT_ENABLE];
    assign conv_valid = {CONV1.valid, CONV0.valid};
    assign conv_data[0] = CONV0.data;
    assign conv_data[1] = CONV1.data;
    assign mem_done = MEM_WR.req && MEM_GNT;
    assign last_word = mem_done && (done_cnt + 16'h0001 >= count);

    ////////////////////////////////////////////////////////////////////////////
    // APB ready: one wait state, registered so the output comes from a flop
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            PREADY <= 1'b0;
        end else begin
            PREADY <= access && !PREADY;
        end
    end

    // Read data and error, presented with ready
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_slverr = 1'b0;
        case (PADDR)
            adcd_pkg::OFS_CTRL: next_prdata = {24'h000000, ctrl_read};
            adcd_pkg::OFS_IRQ_STAT: next_prdata = {24'h000000, flags};
            adcd_pkg::OFS_IRQ_EN: next_prdata = {24'h000000, irq_en};
            adcd_pkg::OFS_COUNT: next_prdata = {16'h0000, count};
            default: next_prdata = 32'h0000_0000; // Clear register reads zero
        endcase
        if (!mapped(PADDR)) begin
            next_slverr = 1'b1;
        end
    end

    // Capture read data in the wait state
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (access && !PREADY) begin
            PRDATA <= PWRITE ? 32'h0000_0000 : next_prdata;
            PSLVERR <= next_slverr;
        end else begin
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control read view
    always_comb begin
        ctrl_read = flags;
        ctrl_read[adcd_pkg::BIT_ENABLE] = (state == adcd_pkg::ST_RUN);
        ctrl_read[adcd_pkg::BIT_MODE] = mode;
        ctrl_read[adcd_pkg::BIT_WARN_EN] = warn_en;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software configuration bits
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            mode <= adcd_pkg::RST_CTRL[adcd_pkg::BIT_MODE];
            warn_en <= adcd_pkg::RST_CTRL[adcd_pkg::BIT_WARN_EN];
            irq_en <= adcd_pkg::RST_IRQ_EN;
            count <= adcd_pkg::RST_COUNT;
        end else begin
            if (ctrl_wr) begin
                mode <= PWDATA[adcd_pkg::BIT_MODE];
                warn_en <= PWDATA[adcd_pkg::BIT_WARN_EN];
            end
            if (wr_now && (PADDR == adcd_pkg::OFS_IRQ_EN)) begin
                irq_en <= PWDATA[7:0] & adcd_pkg::FLAG_MASK;
            end
            if (wr_now && (PADDR == adcd_pkg::OFS_COUNT)) begin
                count <= PWDATA[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Engine state: runs until the programmed words are written or stopped
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            state <= adcd_pkg::ST_IDLE;
            done_cnt <= 16'h0000;
        end else begin
            case (state)
                adcd_pkg::ST_IDLE: begin
                    if (start) begin
                        state <= adcd_pkg::ST_RUN;
                        done_cnt <= 16'h0000;
                    end
                end
                adcd_pkg::ST_RUN: begin
                    if (stop) begin
                        state <= adcd_pkg::ST_IDLE;
                    end else if (last_word) begin
                        state <= adcd_pkg::ST_IDLE;
                    end else if (mem_done) begin
                        done_cnt <= done_cnt + 16'h0001;
                    end
                end
                default: state <= adcd_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-converter double buffer; results are taken only while running
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            buf_full <= 2'b00;
            hold_full <= 2'b00;
            buf_data[0] <= 16'h0000;
            buf_data[1] <= 16'h0000;
            hold_data[0] <= 16'h0000;
            hold_data[1] <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // Draining this buffer frees it for the held word
                if (mem_done && (MEM_WR.sel == i[0])) begin
                    buf_full[i] <= hold_full[i];
                    buf_data[i] <= hold_data[i];
                    hold_full[i] <= 1'b0;
                end
                if (conv_valid[i] && (state == adcd_pkg::ST_RUN)) begin
                    if (!buf_full[i] && !(mem_done && (MEM_WR.sel == i[0]))) begin
                        buf_full[i] <= 1'b1;
                        buf_data[i] <= conv_data[i];
                    end else if (mem_done && (MEM_WR.sel == i[0]) && !hold_full[i]) begin
                        buf_full[i] <= 1'b1;
                        buf_data[i] <= conv_data[i];
                    end else begin
                        // Older held word is overwritten if present, unless it moves to the buffer this cycle
                        hold_full[i] <= 1'b1;
                        hold_data[i] <= conv_data[i];
                    end
                end
                if (stop) begin
                    buf_full[i] <= 1'b0;
                    hold_full[i] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory request: converter 0 first; held until granted
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            MEM_WR <= '0;
        end else if (stop) begin
            // Stop withdraws a pending word
            // An ungranted word must not reach memory after a stop
            MEM_WR.req <= 1'b0;
        end else if (mem_done || !MEM_WR.req) begin
            MEM_WR.req <= 1'b0;
            // No new word once the final grant ends the operation
            if (state == adcd_pkg::ST_RUN && !last_word) begin
                if (buf_full[0] && !(mem_done && !MEM_WR.sel)) begin
                    MEM_WR.req <= 1'b1;
                    MEM_WR.sel <= 1'b0;
                    MEM_WR.data <= buf_data[0];
                end else if (buf_full[1] && !(mem_done && MEM_WR.sel)) begin
                    MEM_WR.req <= 1'b1;
                    MEM_WR.sel <= 1'b1;
                    MEM_WR.data <= buf_data[1];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Hardware flag events
    always_comb begin
        set_flags = 8'h00;
        set_flags[adcd_pkg::BIT_COMPLETE] = (state == adcd_pkg::ST_RUN) && !stop && last_word;
        set_flags[adcd_pkg::BIT_WARN0] = conv_valid[0] && (state == adcd_pkg::ST_RUN) && buf_full[0];
        set_flags[adcd_pkg::BIT_WARN1] = conv_valid[1] && (state == adcd_pkg::ST_RUN) && buf_full[1];
        set_flags[adcd_pkg::BIT_ERR0] = conv_valid[0] && (state == adcd_pkg::ST_RUN) && hold_full[0] &&
                                        !(mem_done && !MEM_WR.sel);
        set_flags[adcd_pkg::BIT_ERR1] = conv_valid[1] && (state == adcd_pkg::ST_RUN) && hold_full[1] &&
                                        !(mem_done && MEM_WR.sel);
    end

    // Software clears: zero written to control, or one written to clear register
    always_comb begin
        clr_flags = 8'h00;
        if (ctrl_wr) begin
            clr_flags = ~PWDATA[7:0] & adcd_pkg::FLAG_MASK;
        end else if (wr_now && (PADDR == adcd_pkg::OFS_IRQ_CLR)) begin
            clr_flags = PWDATA[7:0] & adcd_pkg::FLAG_MASK;
        end
    end

    // Sticky flags; a set in the same cycle as a clear is kept
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            flags <= adcd_pkg::RST_CTRL & adcd_pkg::FLAG_MASK;
        end else begin
            flags <= (flags & ~clr_flags) | set_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs: mode and gated interrupt level
    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            EXEC_MODE <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            EXEC_MODE <= mode;
            IRQ <= |(flags & irq_en & (warn_en ? 8'hFF : ~adcd_pkg::WARN_MASK));
        end
    end
endmodule // adcd_top

// >>> hdl/adcd_pkg.sv
// Purpose: Shared constants and types of the converter-to-memory transfer control block
// Assumes: 32-bit APB data, one aligned word per register
// Notes: Offsets are byte addresses
package adcd_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
    localparam logic [7:0] OFS_COUNT = 8'h10;
    // Control and status field positions
    localparam int BIT_ENABLE = 7;
    localparam int BIT_COMPLETE = 6;
    localparam int BIT_MODE = 5;
    localparam int BIT_ERR1 = 4;
    localparam int BIT_ERR0 = 3;
    localparam int BIT_WARN_EN = 2;
    localparam int BIT_WARN1 = 1;
    localparam int BIT_WARN0 = 0;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    // Flags that can raise the interrupt, in control-register layout
    localparam logic [7:0] FLAG_MASK = 8'h5B;
    localparam logic [7:0] WARN_MASK = 8'h03;
    // Conversion result widths
    localparam int DATA_W = 16;
    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } adcd_state_type;
    // One conversion result from a converter
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } adcd_conv_type;
    // One memory write request
    typedef struct packed {
        logic req;
        logic sel;
        logic [15:0] data;
    } adcd_mem_type;
endpackage : adcd_pkg

// >>> tb/adcd_chk.sv
// Purpose: Port-level assertions for adcd_top
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to adcd_top after the module
module adcd_chk (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // APB
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Memory side and mode
    input wire adcd_pkg::adcd_mem_type MEM_WR,
    input wire logic MEM_GNT,
    input wire logic EXEC_MODE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////////
    // Control write committing at this edge
    logic ctrl_wr;
    assign ctrl_wr = PSEL && PENABLE && PREADY && PWRITE && PADDR == adcd_pkg::OFS_CTRL;
    // Exactly one wait state, then a one-cycle answer
    AST_APB_WAIT: assert property ($rose(PENABLE) && PSEL |=> PREADY)
        else $error("ready not in second access cycle");
    AST_APB_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    AST_UNMAPPED: assert property (PREADY && PADDR > adcd_pkg::OFS_COUNT |-> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped access not refused");
    AST_BUSY_READ: assert property (
        PREADY && !PWRITE && PADDR == adcd_pkg::OFS_CTRL && MEM_WR.req |-> PRDATA[7])
        else $error("busy bit low while words pending");
    AST_STOP_FLUSH: assert property (ctrl_wr && !PWDATA[7] |=> ##1 !MEM_WR.req)
        else $error("stop left a request");
    AST_MODE_OUT: assert property (ctrl_wr |=> ##1 EXEC_MODE == $past(PWDATA[5], 2))
        else $error("mode output wrong");
    // A pending word must not vanish or change before its grant unless the control register is written
    AST_REQ_HOLD: assert property (
        MEM_WR.req && !MEM_GNT && !ctrl_wr |=> MEM_WR.req && $stable(MEM_WR))
        else $error("request dropped before grant");
    AST_ERR_PAIR: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
endmodule // adcd_chk
bind adcd_top adcd_chk adcd_chk_i (.CLK_SYS(CLK_SYS), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .MEM_WR(MEM_WR), .MEM_GNT(MEM_GNT), .EXEC_MODE(EXEC_MODE));

// >>> tb/adcd_mem_model.sv
// Purpose: Memory partner that grants transfer words
// Assumes: Same clock as the block
// Notes: Stall holds the grant low, as a busy memory would
module adcd_mem_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Request side
    input wire adcd_pkg::adcd_mem_type mem_wr,
    input wire logic stall,
    output logic mem_gnt,
    // Observation
    output adcd_pkg::adcd_mem_type last_word,
    output logic [7:0] words
);
    ////////////////////////////////////////////////////////////////////////////
    // Grant one cycle after a request, one word per grant
    always_ff @(posedge clk_sys) begin
        mem_gnt <= nrst && !mem_gnt && mem_wr.req && !stall;
    end
    // Record each accepted word
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            words <= 8'h00;
            last_word <= '0;
        end else if (mem_wr.req && mem_gnt) begin
            words <= words + 8'h01;
            last_word <= mem_wr;
        end
    end
endmodule // adcd_mem_model

// >>> tb/tb_top.sv
// Purpose: Self-checking bench for adcd_top
// Assumes: APB master tasks, converter pulses, memory partner model
// Notes: Table rows cover register access; hand tests cover transfers and flags
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // One register access and what it should give
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} adcd_row_type;
    localparam adcd_row_type ROWS [12] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h0C, 0, 0, 0}, '{0, 8'h10, 0, 0, 0},
        '{0, 8'h04, 0, 0, 0}, '{1, 8'h0C, 32'h5B, 0, 0}, '{0, 8'h0C, 0, 32'h5B, 0}, '{1, 8'h10, 32'h2, 0, 0},
        '{0, 8'h10, 0, 32'h2, 0}, '{1, 8'h00, 32'h24, 0, 0}, '{0, 8'h00, 0, 32'h24, 0}, '{0, 8'h08, 0, 0, 0},
        '{0, 8'h14, 0, 0, 1}};
    ////////////////////////////////////////////////////////////////////////////
    logic clk_sys = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, mem_gnt, exec_mode, irq, er;
    adcd_pkg::adcd_conv_type conv0 = '0, conv1 = '0;
    adcd_pkg::adcd_mem_type mem_wr, last_word;
    logic [7:0] words;
    int failures = 0, compares = 0;
    adcd_top adcd_top_i (.CLK_SYS(clk_sys), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CONV0(conv0),
        .CONV1(conv1), .MEM_WR(mem_wr), .MEM_GNT(mem_gnt), .EXEC_MODE(exec_mode), .IRQ(irq));
    adcd_mem_model adcd_mem_model_i (.clk_sys(clk_sys), .nrst(nrst), .mem_wr(mem_wr), .stall(stall),
        .mem_gnt(mem_gnt), .last_word(last_word), .words(words));
    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    // One APB transfer; request held until ready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // Stop at the edge that samples ready high; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), rd, x);
    endtask
    // One conversion result pulse; data lines change between pulses
    task automatic pulse(input logic s, input logic [15:0] v);
        @(posedge clk_sys);
        if (s) conv1 <= {1'b1, v};
        else conv0 <= {1'b1, v};
        @(posedge clk_sys);
        conv0 <= {1'b0, ~conv0.data};
        conv1 <= {1'b0, ~conv1.data};
    endtask
    task automatic wrap_up();
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Watchdog sized well above the whole sequence
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk_sys);
        nrst <= 1'b1;
        foreach (ROWS[i]) begin
            apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            if (!ROWS[i].w) chk("row data", rd, ROWS[i].r);
            chk("row error", {31'h0, er}, {31'h0, ROWS[i].e});
        end
        apb(1'b1, 8'h00, 32'hA4);
        rchk(8'h00, 32'hA4);
        chk("mode one", {31'h0, exec_mode}, 32'h1);
        pulse(1'b0, 16'h1234);
        pulse(1'b1, 16'hBEEF);
        for (int k = 0; k < 100 && words !== 8'h02; k++) @(posedge clk_sys);
        chk("last word", {14'h0, last_word}, {14'h0, 2'b11, 16'hBEEF});
        rchk(8'h00, 32'h64);
        chk("irq done", {31'h0, irq}, 32'h1);
        rchk(8'h04, 32'h40);
        apb(1'b1, 8'h00, 32'h24);
        rchk(8'h04, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        stall <= 1'b1;
        apb(1'b1, 8'h10, 32'h8);
        apb(1'b1, 8'h00, 32'h84);
        for (int k = 0; k < 6; k++) pulse(k > 2, 16'h0100 + 16'(k));
        rchk(8'h00, 32'h9F);
        chk("mode", {31'h0, exec_mode}, 32'h0);
        chk("irq warn", {31'h0, irq}, 32'h1);
        apb(1'b1, 8'h00, 32'h83);
        rchk(8'h00, 32'h83);
        chk("irq gated", {31'h0, irq}, 32'h0);
        apb(1'b1, 8'h08, 32'h3);
        rchk(8'h00, 32'h80);
        apb(1'b1, 8'h00, 32'h0);
        rchk(8'h00, 32'h0);
        stall <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk("flushed", {24'h0, words}, 32'h2);
        // Reset while running restores defaults
        apb(1'b1, 8'h00, 32'hA0);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        rchk(8'h00, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h0C, 32'h0);
        chk("reset mode", {31'h0, exec_mode}, 32'h0);
        chk("reset irq", {31'h0, irq}, 32'h0);
        chk("reset req", {31'h0, mem_wr.req}, 32'h0);
        wrap_up();
    end
endmodule // tb_top
